// File: bench/tfm_freq_monitor_properties.sv
// concurrent checks on the ports of the link frequency monitor
`timescale 1ns/1ps
module tfm_freq_monitor_properties (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        irq,
    input wire logic        audio_mute_on_clock_change,
    input wire logic        pll_lock_a,
    input wire logic        pll_lock_b
);
    wire       rd_end = avs_read && !avs_waitrequest;
    wire [7:0] ridx   = avs_address[9:2];
    wire       ok_a   = avs_address[1:0] == 2'b00;
    wire       mute   = audio_mute_on_clock_change;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    AST_BUS_ONE_WAIT: assert property (s_take |=> s_answer)
        else $error("bus answer not exactly one wait cycle");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !rstn |=> avs_waitrequest && !irq && !mute)
        else $error("outputs not quiet after reset");
    AST_MUTE_PULSE: assert property (mute |=> !mute)
        else $error("mute longer than one cycle");
    AST_MUTE_LOCKED: assert property (mute |-> $past(pll_lock_a, 3) || $past(pll_lock_b, 3))
        else $error("mute without pll lock");
    AST_IRQ_FALL_CAUSE: assert property ($fell(irq) |-> !$past(rstn)
        || $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("irq fell without a write");
    AST_UNMAPPED_ZERO: assert property (rd_end && !ok_a |-> avs_readdata == 32'h0000_0000)
        else $error("misaligned read not zero");
    AST_FLAG_BITS: assert property (rd_end && ok_a && ridx == 8'h83
        |-> (avs_readdata & 32'hffff_fffd) == 32'h0000_0000)
        else $error("change flag register has stray bits");
    AST_TOL_BITS: assert property (rd_end && ok_a && ridx == 8'h0d
        |-> avs_readdata[31:4] == 28'h000_0000)
        else $error("tolerance wider than four bits");
    AST_LOCK_A_RAW: assert property (rd_end && ok_a && ridx == 8'h6a
        && $past(pll_lock_a, 2) == $past(pll_lock_a, 6)
        |-> avs_readdata[7:0] == {1'b0, $past(pll_lock_a, 4), 6'b00_0000})
        else $error("raw lock bit does not follow port a");
    AST_BG_STATUS_BITS: assert property (rd_end && ok_a && ridx == 8'h92
        |-> avs_readdata[7:2] == 6'b00_0000)
        else $error("background status has stray bits");
endmodule // tfm_freq_monitor_properties

bind tfm_freq_monitor tfm_freq_monitor_properties i_tfm_freq_monitor_properties (
    .ref_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .irq, .audio_mute_on_clock_change, .pll_lock_a, .pll_lock_b
);

// File: bench/tfm_freq_monitor_tb.sv
// self-checking bench of the link frequency monitor
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tfm_freq_monitor_tb;
    localparam int G = 2560;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, irq, audio_mute_on_clock_change;
    logic        link_clk_a, link_clk_b, pll_lock_a, pll_lock_b;
    logic        run_a = 1'b0, run_b = 1'b0, fast_a = 1'b0;
    logic        lock_en_a = 1'b0, lock_en_b = 1'b0;
    int          error_cnt = 0, total_checks = 0, cyc = 0, mute_cnt = 0;

    tfm_freq_monitor #(.GATE_CYCLES(G)) i_tfm_freq_monitor (
        .ref_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_byteenable (4'h1),
        .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .audio_mute_on_clock_change,
        .link_clk_a, .link_clk_b, .pll_lock_a, .pll_lock_b
    );
    tfm_link_source i_tfm_link_source (
        .run_a, .run_b, .fast_a, .lock_en_a, .lock_en_b,
        .link_clk_a, .link_clk_b, .pll_lock_a, .pll_lock_b
    );

    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cyc++;
        if (audio_mute_on_clock_change === 1'b1)
            mute_cnt++;
        if (cyc == 60000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] wd,
                       output logic [7:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, wd};
        avs_write     <= w;
        avs_read      <= !w;
        // no local limit: only the cycle ceiling ends a stuck wait
        do
        begin
            @(posedge ref_clk);
        end
        while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] d;
        bus(1'b0, {i, 2'b00}, 8'h00, d);
        `CHK(d, e)
    endtask

    // one link edge either way is a legal measurement
    task automatic rd_near(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] d;
        bus(1'b0, {i, 2'b00}, 8'h00, d);
        `CHK(d >= e - 8'h01 && d <= e + 8'h01, 1'b1)
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        logic [7:0] d;
        bus(1'b1, {i, 2'b00}, v, d);
    endtask

    task automatic gates(input int k);
        repeat (k * G + 10) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        rd(8'h00, 8'h00);
        rd(8'h0d, 8'h04);
        rd(8'h51, 8'h00);
        rd(8'h52, 8'h00);
        rd(8'h83, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h6a, 8'h00);
        $display("reset values done");
    endtask

    // 2.5 MHz on port a is 2 + 64/128 MHz
    task automatic t_measure();
        run_a     <= 1'b1;
        lock_en_a <= 1'b1;
        gates(2);
        rd(8'h04, 8'h02);
        rd(8'h6a, 8'h40);
        rd(8'h51, 8'h01);
        rd_near(8'h52, 8'h40);
        rd(8'h83, 8'h00);
        $display("measurement done");
    endtask

    task automatic t_change();
        wr(8'h95, 8'h01);
        wr(8'h0d, 8'h01);
        rd(8'h0d, 8'h01);
        rd(8'h95, 8'h01);
        gates(3);
        rd(8'h83, 8'h02);
        rd(8'h94, 8'h01);
        `CHK(irq, 1'b1)
        `CHK(mute_cnt, 1)
        $display("change flag done");
    endtask

    task automatic t_clear();
        wr(8'h90, 8'h01);
        rd(8'h83, 8'h00);
        `CHK(irq, 1'b1)
        wr(8'h94, 8'h01);
        rd(8'h94, 8'h00);
        `CHK(irq, 1'b0)
        $display("clear done");
    endtask

    // 6.25 MHz is 6 + 32/128 MHz, only taken once the pll locks again
    task automatic t_hold();
        lock_en_a <= 1'b0;
        fast_a    <= 1'b1;
        gates(2);
        rd(8'h51, 8'h01);
        rd(8'h04, 8'h00);
        rd(8'h83, 8'h00);
        lock_en_a <= 1'b1;
        gates(2);
        rd(8'h51, 8'h03);
        rd_near(8'h52, 8'h20);
        rd(8'h83, 8'h02);
        `CHK(mute_cnt, 2)
        `CHK(irq, 1'b1)
        $display("lock hold done");
    endtask

    task automatic t_bus_err();
        logic [7:0] d;
        rd(8'h30, 8'h00);
        rd(8'h90, 8'h00);
        bus(1'b0, {8'h51, 2'b01}, 8'h00, d);
        `CHK(d, 8'h00)
        bus(1'b1, {8'h0d, 2'b10}, 8'h07, d);
        rd(8'h0d, 8'h01);
        $display("bus errors done");
    endtask

    task automatic t_bg();
        logic [7:0] d;
        rd(8'he0, 8'h00);
        wr(8'h91, 8'h01);
        rd(8'h91, 8'h01);
        run_b     <= 1'b1;
        lock_en_b <= 1'b1;
        wr(8'h90, 8'h02);
        do
        begin
            bus(1'b0, {8'h92, 2'b00}, 8'h00, d);
        end
        while (d[1] !== 1'b0);
        rd(8'h92, 8'h01);
        rd(8'he0, 8'h01);
        rd_near(8'he1, 8'h40);
        rd(8'h51, 8'h03);
        // primary switched to port b: 2.5 MHz reads whole 2
        wr(8'h00, 8'h01);
        rd(8'h00, 8'h01);
        gates(2);
        rd(8'h51, 8'h01);
        rd(8'h04, 8'h02);
        $display("background done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_measure();
        t_change();
        t_clear();
        t_hold();
        t_bus_err();
        t_bg();
        tally_and_finish();
    end
endmodule // tfm_freq_monitor_tb

// File: bench/tfm_link_source.sv
// behavioural video source: link clocks and pll lock levels of ports a and b
`timescale 1ns/1ps
module tfm_link_source #(
    parameter int HALF_NS = 200
) (
    input  wire logic run_a,
    input  wire logic run_b,
    input  wire logic fast_a,
    input  wire logic lock_en_a,
    input  wire logic lock_en_b,
    output logic      link_clk_a,
    output logic      link_clk_b,
    output logic      pll_lock_a,
    output logic      pll_lock_b
);
    // clocks park low while the source is off, as an idle transmitter does
    initial
    begin
        link_clk_a = 1'b0;
        link_clk_b = 1'b0;
        #7;
        fork
            forever
            begin
                #(fast_a ? 80 : HALF_NS);
                link_clk_a = run_a && !link_clk_a;
            end
            forever
            begin
                #(HALF_NS);
                link_clk_b = run_b && !link_clk_b;
            end
        join
    end
    // a pll cannot report lock without a clock to lock to
    assign pll_lock_a = lock_en_a && run_a;
    assign pll_lock_b = lock_en_b && run_b;
endmodule // tfm_link_source

// File: core/tfm_consts.svh
// register offsets, field positions, reset values and timing counts of the link frequency monitor
`ifndef TFM_CONSTS_SVH
`define TFM_CONSTS_SVH

`define TFM_IDX_PORT_SELECT    8'h00
`define TFM_IDX_PLL_LOCK       8'h04
`define TFM_IDX_TOLERANCE      8'h0d
`define TFM_IDX_FREQ_WHOLE     8'h51
`define TFM_IDX_FREQ_FRAC      8'h52
`define TFM_IDX_LOCK_A_RAW     8'h6a
`define TFM_IDX_CHANGE_FLAG    8'h83
`define TFM_IDX_CONTROL        8'h90
`define TFM_IDX_BG_PORT_SEL    8'h91
`define TFM_IDX_BG_STATUS      8'h92
`define TFM_IDX_IRQ_STATUS     8'h94
`define TFM_IDX_IRQ_MASK       8'h95
`define TFM_IDX_BG_WHOLE       8'he0
`define TFM_IDX_BG_FRAC        8'he1

`define TFM_BIT_PLL_LOCK       1
`define TFM_BIT_LOCK_A_RAW     6
`define TFM_BIT_CHANGE_FLAG    1
`define TFM_BIT_CTRL_CLEAR     0
`define TFM_BIT_CTRL_BG_REQ    1
`define TFM_BIT_BG_VALID       0
`define TFM_BIT_BG_BUSY        1
`define TFM_BIT_IRQ_CHANGE     0

`define TFM_RST_PORT_SELECT    3'h0
`define TFM_RST_TOLERANCE      4'h4
`define TFM_RST_BG_PORT_SEL    3'h0
`define TFM_RST_FREQ           9'h000
`define TFM_RST_FRAC           7'h00

`define TFM_CLK_FREQ_MHZ       20
`define TFM_GATE_TIME_US       128
`define TFM_GATE_CYCLES        (`TFM_GATE_TIME_US * `TFM_CLK_FREQ_MHZ)
`define TFM_FRAC_BITS          7

`endif

// File: core/tfm_freq_monitor.sv
// link clock frequency monitor with change flag, background measurement and avalon slave
// Notes on behaviour
// - measured whole MHz of selected port is a 9-bit field, reset zero
// - fraction is a 7-bit field in 1/128 MHz steps, reset zero
// - frequency readbacks of the selected port are only updated while its pll is locked
// - whole field fills one register and top bit of next; fraction below
// - read-only lock bit of the selected port pll
// - read-only raw lock bit of port a pll
// - change flag sets when frequency moves beyond tolerance, stays until cleared
// - writable 4-bit tolerance in MHz, reset 0100
// - same tolerance drives the audio mute on clock change
// - rising change flag sets a latched interrupt status bit and interrupt
// - background port whole MHz captured into 9 bits only on request
// - background fraction captured by the same request
// - primary port select, reset selects port a, and that port is measured
`timescale 1ns/1ps
`include "tfm_consts.svh"

module tfm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // tfm_sync

module tfm_freq_monitor #(
    parameter int GATE_CYCLES = `TFM_GATE_CYCLES,
    parameter int CNT_W       = 12,
    parameter int EDGE_W      = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    output logic             audio_mute_on_clock_change,
    input  wire logic        link_clk_a,
    input  wire logic        link_clk_b,
    input  wire logic        pll_lock_a,
    input  wire logic        pll_lock_b
);
    import tfm_pkg::*;

    localparam logic [CNT_W-1:0] GATE_LAST = CNT_W'(GATE_CYCLES - 1);

    // synchronised pins
    logic [3:0]          pin_sync;
    logic                clk_a_prev;
    logic                clk_b_prev;
    wire                 clk_a_s    = pin_sync[0];
    wire                 clk_b_s    = pin_sync[1];
    wire                 lock_a_s   = pin_sync[2];
    wire                 lock_b_s   = pin_sync[3];
    wire                 rise_a     = clk_a_s & ~clk_a_prev;
    wire                 rise_b     = clk_b_s & ~clk_b_prev;

    // software state
    tfm_port_sel_t       port_select;
    tfm_port_sel_t       bg_port_select;
    logic [3:0]          tolerance;
    logic                irq_mask;
    logic                irq_status;
    logic                clear_pulse;
    logic                bg_req_pulse;

    // primary measurement
    logic [CNT_W-1:0]    prim_gate;
    logic [EDGE_W-1:0]   prim_edges;
    logic [8:0]          freq_whole;
    logic [6:0]          freq_frac;
    logic [8:0]          ref_whole;
    logic                pll_lock_status;
    logic                port_a_pll_lock_raw;
    logic                freq_change_flag;
    logic                flag_prev;

    // background measurement
    tfm_bg_state_t       bg_state;
    logic [CNT_W-1:0]    bg_gate;
    logic [EDGE_W-1:0]   bg_edges;
    logic [8:0]          bg_whole;
    logic [6:0]          bg_frac;
    logic                bg_valid;

    tfm_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in ({pll_lock_b, pll_lock_a, link_clk_b, link_clk_a}),
        .sync_out (pin_sync)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            clk_a_prev <= 1'b0;
            clk_b_prev <= 1'b0;
        end
        else
        begin
            clk_a_prev <= clk_a_s;
            clk_b_prev <= clk_b_s;
        end
    end

    // port selection; codes other than a and b see no clock and no lock
    wire sel_is_a   = (port_select == 3'h0);
    wire sel_is_b   = (port_select == 3'h1);
    wire sel_rise   = (sel_is_a & rise_a) | (sel_is_b & rise_b);
    wire sel_lock   = (sel_is_a & lock_a_s) | (sel_is_b & lock_b_s);
    wire bg_is_a    = (bg_port_select == 3'h0);
    wire bg_is_b    = (bg_port_select == 3'h1);
    wire bg_rise    = (bg_is_a & rise_a) | (bg_is_b & rise_b);
    wire bg_lock    = (bg_is_a & lock_a_s) | (bg_is_b & lock_b_s);

    // 128 us gate makes the edge count equal MHz times 128
    wire               prim_done  = (prim_gate == GATE_LAST);
    wire [8:0]         new_whole  = prim_edges[EDGE_W-1:`TFM_FRAC_BITS];
    wire [6:0]         new_frac   = prim_edges[`TFM_FRAC_BITS-1:0];
    wire               new_above  = (new_whole > ref_whole);
    wire [8:0]         diff       = new_above ? (new_whole - ref_whole) : (ref_whole - new_whole);
    wire               moved      = (diff > {5'h00, tolerance});
    wire               accept     = prim_done & sel_lock;
    wire               change_evt = accept & moved;
    wire               flag_rise  = freq_change_flag & ~flag_prev;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            prim_gate  <= '0;
            prim_edges <= '0;
        end
        else if (prim_done)
        begin
            prim_gate  <= '0;
            prim_edges <= EDGE_W'(sel_rise);
        end
        else
        begin
            prim_gate  <= prim_gate + CNT_W'(1);
            prim_edges <= prim_edges + EDGE_W'(sel_rise);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            freq_whole <= `TFM_RST_FREQ;
            freq_frac  <= `TFM_RST_FRAC;
        end
        else if (accept)
        begin
            freq_whole <= new_whole;
            freq_frac  <= new_frac;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            ref_whole <= `TFM_RST_FREQ;
        else if (change_evt)
            ref_whole <= new_whole;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pll_lock_status     <= 1'b0;
            port_a_pll_lock_raw <= 1'b0;
        end
        else
        begin
            pll_lock_status     <= sel_lock;
            port_a_pll_lock_raw <= lock_a_s;
        end
    end

    // a detection in the clearing cycle keeps the flag set
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            freq_change_flag <= 1'b0;
            flag_prev        <= 1'b0;
        end
        else
        begin
            if (change_evt)
                freq_change_flag <= 1'b1;
            else if (clear_pulse)
                freq_change_flag <= 1'b0;
            flag_prev <= freq_change_flag;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            audio_mute_on_clock_change <= 1'b0;
        else
            audio_mute_on_clock_change <= change_evt;
    end

    // background single shot
    wire bg_done = (bg_state == TFM_BG_MEAS) && (bg_gate == GATE_LAST);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            bg_state <= TFM_BG_IDLE;
            bg_gate  <= '0;
            bg_edges <= '0;
            bg_whole <= `TFM_RST_FREQ;
            bg_frac  <= `TFM_RST_FRAC;
            bg_valid <= 1'b0;
        end
        else
        begin
            case (bg_state)
                TFM_BG_IDLE:
                begin
                    if (bg_req_pulse)
                    begin
                        bg_state <= TFM_BG_MEAS;
                        bg_gate  <= '0;
                        bg_edges <= '0;
                        bg_valid <= 1'b0;
                    end
                end
                TFM_BG_MEAS:
                begin
                    bg_gate  <= bg_gate + CNT_W'(1);
                    bg_edges <= bg_edges + EDGE_W'(bg_rise);
                    if (bg_done)
                    begin
                        bg_whole <= bg_edges[EDGE_W-1:`TFM_FRAC_BITS];
                        bg_frac  <= bg_edges[`TFM_FRAC_BITS-1:0];
                        bg_valid <= bg_lock;
                        bg_state <= TFM_BG_IDLE;
                    end
                end
                default:
                begin
                    bg_state <= TFM_BG_IDLE;
                end
            endcase
        end
    end

    // avalon slave: one wait cycle, data and write effect at the second edge
    wire [7:0] idx     = avs_address[9:2];
    wire       addr_ok = (avs_address[1:0] == 2'h0);
    wire       req     = avs_read | avs_write;
    wire       wr_fire = avs_write & ~avs_waitrequest & addr_ok & avs_byteenable[0];
    wire [7:0] wbyte   = avs_writedata[7:0];

    wire hit_psel  = addr_ok & (idx == `TFM_IDX_PORT_SELECT);
    wire hit_lock  = addr_ok & (idx == `TFM_IDX_PLL_LOCK);
    wire hit_tol   = addr_ok & (idx == `TFM_IDX_TOLERANCE);
    wire hit_whole = addr_ok & (idx == `TFM_IDX_FREQ_WHOLE);
    wire hit_frac  = addr_ok & (idx == `TFM_IDX_FREQ_FRAC);
    wire hit_rawa  = addr_ok & (idx == `TFM_IDX_LOCK_A_RAW);
    wire hit_flag  = addr_ok & (idx == `TFM_IDX_CHANGE_FLAG);
    wire hit_ctrl  = addr_ok & (idx == `TFM_IDX_CONTROL);
    wire hit_bgsel = addr_ok & (idx == `TFM_IDX_BG_PORT_SEL);
    wire hit_bgst  = addr_ok & (idx == `TFM_IDX_BG_STATUS);
    wire hit_ist   = addr_ok & (idx == `TFM_IDX_IRQ_STATUS);
    wire hit_imsk  = addr_ok & (idx == `TFM_IDX_IRQ_MASK);
    wire hit_bgw   = addr_ok & (idx == `TFM_IDX_BG_WHOLE);
    wire hit_bgf   = addr_ok & (idx == `TFM_IDX_BG_FRAC);

    wire [7:0] v_psel  = {5'h00, port_select};
    wire [7:0] v_lock  = 8'(pll_lock_status) << `TFM_BIT_PLL_LOCK;
    wire [7:0] v_tol   = {4'h0, tolerance};
    wire [7:0] v_whole = freq_whole[8:1];
    wire [7:0] v_frac  = {freq_whole[0], freq_frac};
    wire [7:0] v_rawa  = 8'(port_a_pll_lock_raw) << `TFM_BIT_LOCK_A_RAW;
    wire [7:0] v_flag  = 8'(freq_change_flag) << `TFM_BIT_CHANGE_FLAG;
    wire [7:0] v_bgsel = {5'h00, bg_port_select};
    wire       bg_busy = (bg_state == TFM_BG_MEAS);
    wire [7:0] v_bgst  = {6'h00, bg_busy, bg_valid};
    wire [7:0] v_ist   = {7'h00, irq_status};
    wire [7:0] v_imsk  = {7'h00, irq_mask};
    wire [7:0] v_bgw   = bg_whole[8:1];
    wire [7:0] v_bgf   = {bg_whole[0], bg_frac};

    // unmapped and control reads return zero
    wire [7:0] rd_byte = ({8{hit_psel}}  & v_psel)  | ({8{hit_lock}} & v_lock)
                       | ({8{hit_tol}}   & v_tol)   | ({8{hit_whole}} & v_whole)
                       | ({8{hit_frac}}  & v_frac)  | ({8{hit_rawa}} & v_rawa)
                       | ({8{hit_flag}}  & v_flag)  | ({8{hit_bgsel}} & v_bgsel)
                       | ({8{hit_bgst}}  & v_bgst)  | ({8{hit_ist}}  & v_ist)
                       | ({8{hit_imsk}}  & v_imsk)  | ({8{hit_bgw}}  & v_bgw)
                       | ({8{hit_bgf}}   & v_bgf);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest)
                avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            port_select    <= `TFM_RST_PORT_SELECT;
            bg_port_select <= `TFM_RST_BG_PORT_SEL;
            tolerance      <= `TFM_RST_TOLERANCE;
            irq_mask       <= 1'b0;
        end
        else if (wr_fire)
        begin
            if (hit_psel)
                port_select <= wbyte[2:0];
            if (hit_bgsel)
                bg_port_select <= wbyte[2:0];
            if (hit_tol)
                tolerance <= wbyte[3:0];
            if (hit_imsk)
                irq_mask <= wbyte[`TFM_BIT_IRQ_CHANGE];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            clear_pulse  <= 1'b0;
            bg_req_pulse <= 1'b0;
        end
        else
        begin
            clear_pulse  <= wr_fire & hit_ctrl & wbyte[`TFM_BIT_CTRL_CLEAR];
            bg_req_pulse <= wr_fire & hit_ctrl & wbyte[`TFM_BIT_CTRL_BG_REQ];
        end
    end

    // set wins over a write-one-to-clear in the same cycle
    wire ist_clear = wr_fire & hit_ist & wbyte[`TFM_BIT_IRQ_CHANGE];

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            irq_status <= 1'b0;
            irq        <= 1'b0;
        end
        else
        begin
            if (flag_rise)
                irq_status <= 1'b1;
            else if (ist_clear)
                irq_status <= 1'b0;
            irq <= (irq_status | flag_rise) & irq_mask & ~(ist_clear & ~flag_rise);
        end
    end

endmodule // tfm_freq_monitor

// File: core/tfm_pkg.sv
// types shared by the link frequency monitor
package tfm_pkg;

    typedef logic [2:0] tfm_port_sel_t;

    typedef enum logic [1:0]
    {
        TFM_BG_IDLE = 2'b01,
        TFM_BG_MEAS = 2'b10
    } tfm_bg_state_t;

endpackage
